/* File: cppc_map.svh */
// Timing constants and reset values for the charge path protection control
`ifndef CPPC_MAP_SVH
`define CPPC_MAP_SVH
`define CPPC_CLK_HZ 25000000
`define CPPC_TICK_NS 1000
`define CPPC_TICK_CYC ((`CPPC_CLK_HZ / 1000000) * `CPPC_TICK_NS / 1000)
`define CPPC_POWERUP_US 10000
`define CPPC_BLANK_US 180
`define CPPC_RAMP_US 1000
`define CPPC_LATCH_COUNT 16
`define CPPC_CNT_RST 4'h0
`define CPPC_DRIVE_RST 8'h00
`endif

/* File: cppc_pkg.sv */
// Types for the charge path protection control
`default_nettype none
package cppc_pkg;
   typedef enum logic [2:0] {
      CPPC_WAIT = 3'b000,
      CPPC_RAMP = 3'b001,
      CPPC_ON = 3'b010,
      CPPC_OFF = 3'b011,
      CPPC_LATCHED = 3'b100
   } cppc_state_t;
endpackage : cppc_pkg
`default_nettype wire

/* File: cppc_tick.sv */
// Time base divider producing one-cycle microsecond tick pulses
`timescale 1ns/1ns
`default_nettype none
module cppc_tick #(
   parameter int DIV = 25
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   output logic tick
);
   logic [15:0] cnt_r;
   // Count core cycles, pulse once each division
   always_ff @(posedge core_clk) begin
      if (sys_rst || cnt_r == 16'(DIV - 1)) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end
   assign tick = (cnt_r == 16'(DIV - 1)) && !sys_rst;
endmodule : cppc_tick
`default_nettype wire

/* File: cppc_ctrl.sv */
// Charge path protection control: power-up, soft-start, trips and latch-off
//
// Contract
// - Switch off while supply below reset threshold
// - Wait 10 ms, reset state, soft-start
// - Soft-start ramps switch drive gradually
// - Input overvoltage turns switch off immediately
// - Input overvoltage clear reruns soft-start
// - No soft-start if overvoltage at wait end
// - Battery overvoltage blanked 180 us before trip
// - Sixteen battery overvoltage trips latch off
// - Supply cycle clears counter, restarts power-up
// - Overcurrent checked only while switch on
// - Overcurrent must persist 180 us to trip
// - Sixteen overcurrent trips latch off
// - Overcurrent latch cleared by supply or enable
// - Off at 150 C until below 110 C
// - Fault low during any overvoltage or overcurrent event
// - Enable active low; high removes output
`timescale 1ns/1ns
`default_nettype none
`include "cppc_map.svh"
module cppc_ctrl #(
   parameter int TICK_CYC = `CPPC_TICK_CYC,
   parameter int POWERUP_TICKS = `CPPC_POWERUP_US,
   parameter int BLANK_TICKS = `CPPC_BLANK_US,
   parameter int RAMP_TICKS = `CPPC_RAMP_US,
   parameter int DRIVE_W = 8
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic enable_n,
   input wire logic input_overvoltage_cmp,
   input wire logic battery_overvoltage_cmp,
   input wire logic overcurrent_cmp,
   input wire logic overtemp_hot,
   input wire logic overtemp_cool,
   output logic series_power_switch,
   output logic [DRIVE_W-1:0] switch_drive,
   output logic fault_o,
   output logic fault_oe_n,
   output logic overvoltage_trip,
   output logic overcurrent_trip
);
   cppc_pkg::cppc_state_t state_r;
   logic tick;
   logic [15:0] wait_r;
   logic [15:0] ramp_r;
   logic [15:0] bov_blank_r;
   logic [15:0] oc_blank_r;
   logic [3:0] bov_cnt_r;
   logic [3:0] oc_cnt_r;
   logic bov_latch_r;
   logic oc_latch_r;
   logic hot_r;
   logic enable_n_d_r;
   logic bov_trip_r;
   logic oc_trip_r;
   logic [DRIVE_W-1:0] drive_r;
   logic sw_on;
   logic bov_fire;
   logic oc_fire;
   logic block_on;
   logic en_cleared;

   // Shared microsecond time base
   cppc_tick #(.DIV(TICK_CYC)) u_tick (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .tick(tick)
   );

   assign sw_on = (state_r == cppc_pkg::CPPC_RAMP) || (state_r == cppc_pkg::CPPC_ON);
   // Blanking expiry with the condition still present
   assign bov_fire = sw_on && battery_overvoltage_cmp && tick
      && bov_blank_r == 16'(BLANK_TICKS - 1);
   assign oc_fire = sw_on && overcurrent_cmp && tick
      && oc_blank_r == 16'(BLANK_TICKS - 1);
   // Anything that forbids the switch being on
   // The raw hot flag acts at once, the held flag keeps the switch off until cool
   assign block_on = input_overvoltage_cmp || enable_n || overtemp_hot || hot_r
      || bov_latch_r || oc_latch_r;
   assign en_cleared = enable_n_d_r && !enable_n;

   // Power-up wait counter after supply reset release
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wait_r <= 16'h0000;
      end else if (state_r == cppc_pkg::CPPC_WAIT && tick) begin
         wait_r <= wait_r + 16'h0001;
      end
   end

   // Main sequencer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_r <= cppc_pkg::CPPC_WAIT;
      end else begin
         unique case (state_r)
            cppc_pkg::CPPC_WAIT: begin
               if (wait_r == 16'(POWERUP_TICKS)) begin
                  state_r <= block_on ? cppc_pkg::CPPC_OFF
                     : cppc_pkg::CPPC_RAMP;
               end
            end
            cppc_pkg::CPPC_RAMP, cppc_pkg::CPPC_ON: begin
               if (block_on || bov_fire || oc_fire) begin
                  state_r <= cppc_pkg::CPPC_OFF;
               end else if (state_r == cppc_pkg::CPPC_RAMP && ramp_r == 16'(RAMP_TICKS)) begin
                  state_r <= cppc_pkg::CPPC_ON;
               end
            end
            cppc_pkg::CPPC_OFF: begin
               if (bov_latch_r || oc_latch_r) begin
                  state_r <= cppc_pkg::CPPC_LATCHED;
               end else if (!block_on && !battery_overvoltage_cmp && !overcurrent_cmp) begin
                  state_r <= cppc_pkg::CPPC_RAMP;
               end
            end
            cppc_pkg::CPPC_LATCHED: begin
               if (!bov_latch_r && !oc_latch_r) begin
                  state_r <= cppc_pkg::CPPC_OFF;
               end
            end
            default: state_r <= cppc_pkg::CPPC_WAIT;
         endcase
      end
   end

   // Soft-start ramp of the gate drive level
   always_ff @(posedge core_clk) begin
      if (sys_rst || state_r != cppc_pkg::CPPC_RAMP) begin
         ramp_r <= 16'h0000;
      end else if (tick && ramp_r != 16'(RAMP_TICKS)) begin
         ramp_r <= ramp_r + 16'h0001;
      end
   end

   // Drive register: scaled ramp, full when on, zero otherwise
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         drive_r <= `CPPC_DRIVE_RST;
      end else if (state_r == cppc_pkg::CPPC_ON && !block_on && !bov_fire && !oc_fire) begin
         drive_r <= '1;
      end else if (state_r == cppc_pkg::CPPC_RAMP && !block_on && !bov_fire && !oc_fire) begin
         drive_r <= DRIVE_W'((32'(ramp_r) * ((1 << DRIVE_W) - 1)) / RAMP_TICKS);
      end else begin
         drive_r <= '0;
      end
   end

   // Battery overvoltage blanking timer
   always_ff @(posedge core_clk) begin
      if (sys_rst || !sw_on || !battery_overvoltage_cmp || bov_fire) begin
         bov_blank_r <= 16'h0000;
      end else if (tick) begin
         bov_blank_r <= bov_blank_r + 16'h0001;
      end
   end

   // Overcurrent persistence timer, only with switch conducting
   always_ff @(posedge core_clk) begin
      if (sys_rst || !sw_on || !overcurrent_cmp || oc_fire) begin
         oc_blank_r <= 16'h0000;
      end else if (tick) begin
         oc_blank_r <= oc_blank_r + 16'h0001;
      end
   end

   // Battery overvoltage event counter and latch, cleared only by supply reset
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bov_cnt_r <= `CPPC_CNT_RST;
         bov_latch_r <= 1'b0;
      end else if (bov_fire) begin
         bov_cnt_r <= bov_cnt_r + 4'h1;
         if (bov_cnt_r == 4'(`CPPC_LATCH_COUNT - 1)) begin
            bov_latch_r <= 1'b1;
         end
      end
   end

   // Overcurrent counter and latch, cleared by supply or enable toggle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         oc_cnt_r <= `CPPC_CNT_RST;
         oc_latch_r <= 1'b0;
      end else if (oc_fire) begin
         oc_cnt_r <= oc_cnt_r + 4'h1;
         if (oc_cnt_r == 4'(`CPPC_LATCH_COUNT - 1)) begin
            oc_latch_r <= 1'b1;
         end
      end else if (en_cleared) begin
         oc_cnt_r <= `CPPC_CNT_RST;
         oc_latch_r <= 1'b0;
      end
   end

   // Enable history for toggle detection
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         enable_n_d_r <= 1'b0;
      end else begin
         enable_n_d_r <= enable_n;
      end
   end

   // Thermal hysteresis: set at hot, release only when cool
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         hot_r <= 1'b0;
      end else if (overtemp_hot) begin
         hot_r <= 1'b1;
      end else if (overtemp_cool) begin
         hot_r <= 1'b0;
      end
   end

   // Trip indications held while the event is active, the overcurrent one only while the switch is also on
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bov_trip_r <= 1'b0;
         oc_trip_r <= 1'b0;
      end else begin
         bov_trip_r <= bov_fire || (bov_trip_r && battery_overvoltage_cmp);
         oc_trip_r <= oc_fire || (oc_trip_r && overcurrent_cmp && sw_on);
      end
   end

   // Registered outputs
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         overvoltage_trip <= 1'b0;
         overcurrent_trip <= 1'b0;
         fault_oe_n <= 1'b1;
      end else begin
         overvoltage_trip <= input_overvoltage_cmp || bov_trip_r || bov_fire || bov_latch_r;
         overcurrent_trip <= oc_trip_r || oc_fire || oc_latch_r;
         fault_oe_n <= !(input_overvoltage_cmp || bov_trip_r || bov_fire || oc_trip_r
            || oc_fire || bov_latch_r || oc_latch_r);
      end
   end

   assign fault_o = 1'b0;
   assign switch_drive = drive_r;
   assign series_power_switch = |drive_r;
endmodule : cppc_ctrl
`default_nettype wire

/* File: cppc_ctrl_sva.sv */
// Concurrent checks on the charge path protection control ports
`timescale 1ns/1ns
`default_nettype none
module cppc_ctrl_sva #(
   parameter int DRIVE_W = 8
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic enable_n,
   input wire logic input_overvoltage_cmp,
   input wire logic battery_overvoltage_cmp,
   input wire logic overtemp_hot,
   input wire logic series_power_switch,
   input wire logic [DRIVE_W-1:0] switch_drive,
   input wire logic fault_o,
   input wire logic fault_oe_n,
   input wire logic overvoltage_trip,
   input wire logic overcurrent_trip
);
   // All checks share the core clock and the supply reset
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   property p_pwr; $fell(sys_rst) |-> !series_power_switch [*8]; endproperty
   a_pwr: assert property (p_pwr) else $error("switch on during power-up wait");
   property p_iov; input_overvoltage_cmp |=> switch_drive == 0; endproperty
   a_iov: assert property (p_iov) else $error("drive kept under input overvoltage");
   property p_ramp; $past(switch_drive) == 0 && switch_drive != 0 |-> switch_drive != '1;
   endproperty
   a_ramp: assert property (p_ramp) else $error("drive jumped to full");
   property p_blank; $rose(battery_overvoltage_cmp) && !overvoltage_trip
      |=> !overvoltage_trip [*3]; endproperty
   a_blank: assert property (p_blank) else $error("battery trip inside blanking");
   property p_oc; $rose(overcurrent_trip) |-> $past(series_power_switch); endproperty
   a_oc: assert property (p_oc) else $error("overcurrent trip with switch off");
   property p_hot; overtemp_hot |=> switch_drive == 0; endproperty
   a_hot: assert property (p_hot) else $error("drive kept while hot");
   property p_en; enable_n |=> switch_drive == 0; endproperty
   a_en: assert property (p_en) else $error("drive kept while disabled");
   property p_fo; fault_o == 1'b0 && fault_oe_n == !(overvoltage_trip || overcurrent_trip);
   endproperty
   a_fo: assert property (p_fo) else $error("fault pin disagrees with trips");
endmodule : cppc_ctrl_sva
bind cppc_ctrl cppc_ctrl_sva #(.DRIVE_W(DRIVE_W)) u_sva (.core_clk, .sys_rst, .enable_n,
   .input_overvoltage_cmp, .battery_overvoltage_cmp, .overtemp_hot, .series_power_switch,
   .switch_drive, .fault_o, .fault_oe_n, .overvoltage_trip, .overcurrent_trip);
`default_nettype wire

/* File: cppc_host.sv */
// Host side model: enable driver and pulled-up fault line
`timescale 1ns/1ns
`default_nettype none
module cppc_host (
   input wire logic host_off,
   input wire logic fault_o,
   input wire logic fault_oe_n,
   output logic enable_n,
   output logic fault_pin
);
   // Enable low runs the device; a high pulse clears the current latch
   assign enable_n = host_off;
   // Pull-up wins whenever the device releases the pin
   assign fault_pin = fault_oe_n ? 1'b1 : fault_o;
endmodule : cppc_host
`default_nettype wire

/* File: cppc_ctrl_tb.sv */
// Self-checking bench for the charge path protection control
`timescale 1ns/1ns
`default_nettype none
module cppc_ctrl_tb;
   logic core_clk, sys_rst, enable_n, input_overvoltage_cmp, battery_overvoltage_cmp;
   logic overcurrent_cmp, overtemp_hot, overtemp_cool, host_off, fault_pin;
   logic series_power_switch, fault_o, fault_oe_n, overvoltage_trip, overcurrent_trip;
   logic [7:0] switch_drive;
   int errors, checks;
   // Short counts keep the run brief
   cppc_ctrl #(.TICK_CYC(2), .POWERUP_TICKS(20), .BLANK_TICKS(4), .RAMP_TICKS(8)) dut (
      .core_clk, .sys_rst, .enable_n, .input_overvoltage_cmp, .battery_overvoltage_cmp,
      .overcurrent_cmp, .overtemp_hot, .overtemp_cool, .series_power_switch, .switch_drive,
      .fault_o, .fault_oe_n, .overvoltage_trip, .overcurrent_trip);
   cppc_host u_host (.host_off, .fault_o, .fault_oe_n, .enable_n, .fault_pin);
   // 25 MHz clock
   initial begin
      core_clk = 0;
      forever #20 core_clk = ~core_clk;
   end
   task cyc(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task chk(logic [7:0] e, logic [7:0] a);
      checks++;
      if (a !== e) begin
         errors++;
         $display("BAD %0t %h %h", $time, e, a);
      end
   endtask : chk
   // Bounded wait for the switch to reach a level
   task wait_sw(logic v);
      for (int i = 0; i < 300 && series_power_switch !== v; i++) cyc(1);
      chk(v, series_power_switch);
   endtask : wait_sw
   // Run n trips of one kind, each retried after the cause clears
   task trips(int n, bit k);
      for (int i = 0; i < n; i++) begin
         wait_sw(1);
         if (k) overcurrent_cmp = 1;
         else battery_overvoltage_cmp = 1;
         wait_sw(0);
         chk(1, k ? overcurrent_trip : overvoltage_trip);
         chk(0, fault_pin);
         overcurrent_cmp = 0;
         battery_overvoltage_cmp = 0;
      end
      // Only the sixteenth trip of a kind latches; fewer leave a retry running
      cyc(100);
      chk(n < 16 ? 8'h01 : 8'h00, series_power_switch);
      chk(n < 16 ? 8'h01 : 8'h00, fault_pin);
   endtask : trips
   task s_iov;
      cyc(100);
      chk(0, series_power_switch);
      input_overvoltage_cmp = 0;
      wait_sw(1);
      chk(1, switch_drive != 8'hff);
      cyc(30);
      chk(8'hff, switch_drive);
      input_overvoltage_cmp = 1;
      cyc(1);
      chk(0, switch_drive);
      cyc(2);
      chk(0, fault_pin);
      input_overvoltage_cmp = 0;
      wait_sw(1);
   endtask : s_iov
   task s_bov;
      battery_overvoltage_cmp = 1;
      cyc(3);
      battery_overvoltage_cmp = 0;
      cyc(20);
      chk(1, series_power_switch);
      chk(0, overvoltage_trip);
      trips(16, 0);
      sys_rst = 1;
      cyc(4);
      sys_rst = 0;
      cyc(30);
      chk(0, series_power_switch);
      trips(15, 0);
      sys_rst = 1;
      cyc(4);
      sys_rst = 0;
      trips(1, 0);
      sys_rst = 1;
      cyc(4);
      sys_rst = 0;
   endtask : s_bov
   task s_oc;
      wait_sw(1);
      overcurrent_cmp = 1;
      cyc(3);
      overcurrent_cmp = 0;
      cyc(5);
      chk(0, overcurrent_trip);
      chk(1, series_power_switch);
      host_off = 1;
      cyc(3);
      chk(0, series_power_switch);
      overcurrent_cmp = 1;
      cyc(30);
      chk(0, overcurrent_trip);
      overcurrent_cmp = 0;
      host_off = 0;
      trips(16, 1);
      host_off = 1;
      cyc(3);
      host_off = 0;
      wait_sw(1);
   endtask : s_oc
   task s_hot;
      overtemp_cool = 0;
      overtemp_hot = 1;
      cyc(2);
      chk(0, series_power_switch);
      overtemp_hot = 0;
      cyc(50);
      chk(0, series_power_switch);
      overtemp_cool = 1;
      wait_sw(1);
   endtask : s_hot
   task report_and_stop;
      if (errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop
   // Main sequence, starting in reset with input overvoltage present
   initial begin
      {battery_overvoltage_cmp, overcurrent_cmp, overtemp_hot, host_off} = 4'h0;
      {sys_rst, input_overvoltage_cmp, overtemp_cool} = 3'h7;
      cyc(4);
      sys_rst = 0;
      s_iov;
      s_bov;
      s_oc;
      s_hot;
      report_and_stop;
   end
   // Watchdog against a hang
   initial begin
      #2000000;
      errors++;
      report_and_stop;
   end
endmodule : cppc_ctrl_tb
`default_nettype wire
